// File: include/adp_pkg.sv
// ----------------------------------------------------------------------------
// Constants shared by the address/data port pair
// ----------------------------------------------------------------------------
package adp_pkg;

  // Register index width; the byte address on the bus is four times the index
  localparam int unsigned IDX_W = 16;
  localparam int unsigned PORT_W = 8;

  // Register indices (low 16 bits of the internal address)
  localparam logic [15:0] IDX_ADDR_DIR    = 16'hFEBB;
  localparam logic [15:0] IDX_ADDR_LATCH  = 16'hFF6B;
  localparam logic [15:0] IDX_ADDR_PINS   = 16'hFF5B;
  localparam logic [15:0] IDX_ADDR_PULLUP = 16'hFF72;
  localparam logic [15:0] IDX_DATA_DIR    = 16'hFEBC;
  localparam logic [15:0] IDX_DATA_LATCH  = 16'hFF6C;
  localparam logic [15:0] IDX_DATA_PINS   = 16'hFF5C;
  localparam logic [15:0] IDX_DATA_PULLUP = 16'hFF73;

  // Values after power-on reset and in hardware standby
  localparam logic [7:0] RST_PORT_REG = 8'h00;
  // Value returned by a read of a write-only direction register
  localparam logic [7:0] RD_WRITE_ONLY = 8'h00;

  // Number of low address bits that must be zero
  localparam int unsigned ADDR_LSB = 2;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operating mode codes
  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_2 = 3'h2;
  localparam logic [2:0] MODE_3 = 3'h3;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_5 = 3'h5;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_7 = 3'h7;

  // How a port's pins are used in the current mode
  typedef enum logic [1:0] {MC_NONE, MC_EXT, MC_MIXED, MC_PORT} adp_mode_class_e;

endpackage

// File: include/adp_regbus_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Internal register access between bus slave and register file
// ----------------------------------------------------------------------------
interface adp_regbus_if #(parameter int unsigned IDX_W = 16);
  logic             wr_en;
  logic             wr_be;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0]       wr_data;
  logic             wr_hit;
  logic             rd_en;
  logic [IDX_W-1:0] rd_idx;
  logic             rd_hit;
  logic [7:0]       rd_data;

  modport slv  (output wr_en, wr_be, wr_idx, wr_data, rd_en, rd_idx,
                input  wr_hit, rd_hit, rd_data);
  modport regs (input  wr_en, wr_be, wr_idx, wr_data, rd_en, rd_idx,
                output wr_hit, rd_hit, rd_data);
endinterface
`default_nettype wire

// File: rtl/adp_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// AXI4-Lite slave front end
// ----------------------------------------------------------------------------
module adp_axil_slave #(
  parameter int unsigned ADDR_W = 18
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // Register side
  adp_regbus_if.slv              bus
);
  logic [ADDR_W-1:0] awaddr_reg;
  logic [ADDR_W-1:0] araddr_reg;
  logic [7:0]        wdata_reg;
  logic              wbe_reg;

  // Elaboration check: the index must fill the address above the byte lanes
  if (ADDR_W != adp_pkg::IDX_W + adp_pkg::ADDR_LSB) begin : g_bad_addr_w
    $error("ADDR_W must equal the index width plus two");
  end

  // Write address and data are each held until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  // Payload capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= '0;
      araddr_reg <= '0;
      wdata_reg  <= 8'h00;
      wbe_reg    <= 1'b0;
    end else begin
      if (awvalid && awready) awaddr_reg <= awaddr;
      if (arvalid && arready) araddr_reg <= araddr;
      if (wvalid && wready) begin
        wdata_reg <= wdata[7:0];
        wbe_reg   <= wstrb[0];
      end
    end
  end

  // Register access strobes, one cycle once both halves are held
  assign bus.wr_en   = !awready && !wready && !bvalid;
  assign bus.wr_be   = wbe_reg;
  assign bus.wr_idx  = awaddr_reg[ADDR_W-1:adp_pkg::ADDR_LSB];
  assign bus.wr_data = wdata_reg;
  assign bus.rd_en   = !arready && !rvalid;
  assign bus.rd_idx  = araddr_reg[ADDR_W-1:adp_pkg::ADDR_LSB];

  // Write response; misaligned or unmapped answers SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= adp_pkg::RESP_OKAY;
    end else if (bus.wr_en) begin
      bvalid <= 1'b1;
      bresp  <= (bus.wr_hit && awaddr_reg[1:0] == 2'h0) ? adp_pkg::RESP_OKAY
                                                        : adp_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read address and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= adp_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
    end else if (bus.rd_en) begin
      rvalid <= 1'b1;
      if (bus.rd_hit && araddr_reg[1:0] == 2'h0) begin
        rdata <= {24'h00_0000, bus.rd_data};
        rresp <= adp_pkg::RESP_OKAY;
      end else begin
        rdata <= 32'h0000_0000;
        rresp <= adp_pkg::RESP_SLVERR;
      end
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: rtl/adp_port_pair.sv
// What this block does
// - Modes 1,4,5: address port drives address on every pin except in standby.
// - Modes 2,6: direction 1 drives address bit.
// - Modes 3,7: direction 1 drives address latch.
// - Address latch read/write, cleared by power-on/standby.
// - Address pin-state register read-only, writes ignored.
// - Address pin read: latch if output, else pin.
// - Address pull-up only modes 2,3,6,7, input, enabled.
// - Address pull-up control read/write, cleared like latch.
// - Pull-ups off after power-on, kept through manual reset.
// - Modes 1,2,4,5,6: data port is data bus.
// - Modes 3,7: data direction 1 drives data latch.
// - Data direction write-only, reads undefined, cleared.
// - Data latch read/write, cleared by power-on/standby.
// - Data port registers at their fixed indices.
// - Data pull-up control read/write, cleared; pin state read-only.
// - Address direction write-only, reads undefined, cleared.
// - Data pin read: latch if output, else pin.
// - Data pull-up only modes 3,7, input, enabled.
`timescale 1ns/1ps
`default_nettype none
module adp_port_pair #(
  parameter int unsigned ADDR_W = 18,
  parameter int unsigned PORT_W = 8
) (
  // Clock and reset (power-on)
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // System state
  input  wire logic              hw_standby,
  input  wire logic              manual_reset,
  input  wire logic [2:0]        op_mode,
  // Bus controller side
  input  wire logic [PORT_W-1:0] bc_addr,
  input  wire logic [PORT_W-1:0] bc_data_out,
  input  wire logic              bc_data_oe,
  output var  logic [PORT_W-1:0] bc_data_in,
  // Address port pins
  input  wire logic [PORT_W-1:0] addr_pin_i,
  output var  logic [PORT_W-1:0] addr_pin_o,
  output var  logic [PORT_W-1:0] addr_pin_oe,
  output var  logic [PORT_W-1:0] addr_pin_pullup,
  // Data port pins
  input  wire logic [PORT_W-1:0] data_pin_i,
  output var  logic [PORT_W-1:0] data_pin_o,
  output var  logic [PORT_W-1:0] data_pin_oe,
  output var  logic [PORT_W-1:0] data_pin_pullup,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready
);

  // --------------------------------------------------------------------------
  // Parameter checks
  // --------------------------------------------------------------------------
  // Elaboration check: every register is one byte wide
  if (PORT_W != adp_pkg::PORT_W) begin : g_bad_port_w
    $error("PORT_W must be 8: registers are one byte wide");
  end

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [PORT_W-1:0]        addr_dir_reg;
  logic [PORT_W-1:0]        addr_latch_reg;
  logic [PORT_W-1:0]        addr_pullup_reg;
  logic [PORT_W-1:0]        data_dir_reg;
  logic [PORT_W-1:0]        data_latch_reg;
  logic [PORT_W-1:0]        data_pullup_reg;
  logic [PORT_W-1:0]        addr_pin_sync;
  logic [PORT_W-1:0]        data_pin_sync;
  logic [PORT_W-1:0]        addr_pin_state;
  logic [PORT_W-1:0]        data_pin_state;
  logic [PORT_W-1:0]        addr_o_next;
  logic [PORT_W-1:0]        addr_oe_next;
  logic [PORT_W-1:0]        addr_pu_next;
  logic [PORT_W-1:0]        data_o_next;
  logic [PORT_W-1:0]        data_oe_next;
  logic [PORT_W-1:0]        data_pu_next;
  logic                     clear_regs;
  adp_pkg::adp_mode_class_e addr_class;
  adp_pkg::adp_mode_class_e data_class;

  adp_regbus_if #(.IDX_W(adp_pkg::IDX_W)) bus ();

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Index belongs to one of the eight port registers
  function automatic logic is_mapped(input logic [adp_pkg::IDX_W-1:0] idx);
    is_mapped = (idx == adp_pkg::IDX_ADDR_DIR)   || (idx == adp_pkg::IDX_ADDR_LATCH) ||
                (idx == adp_pkg::IDX_ADDR_PINS)  || (idx == adp_pkg::IDX_ADDR_PULLUP) ||
                (idx == adp_pkg::IDX_DATA_DIR)   || (idx == adp_pkg::IDX_DATA_LATCH) ||
                (idx == adp_pkg::IDX_DATA_PINS)  || (idx == adp_pkg::IDX_DATA_PULLUP);
  endfunction

  // Accepted byte write to one register; refused while manual reset holds
  function automatic logic wr_to(input logic [adp_pkg::IDX_W-1:0] idx);
    wr_to = bus.wr_en && bus.wr_be && !manual_reset && (bus.wr_idx == idx);
  endfunction

  // Pin-state view: latch for output bits, pin level for input bits
  function automatic logic [7:0] pin_view(input logic [7:0] dir,
                                          input logic [7:0] latch,
                                          input logic [7:0] pins);
    pin_view = (dir & latch) | (~dir & pins);
  endfunction

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  adp_axil_slave #(.ADDR_W(ADDR_W)) u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .bus     (bus.slv)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  adp_sync #(.WIDTH(PORT_W)) u_addr_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (addr_pin_i),
    .sync_out (addr_pin_sync)
  );

  adp_sync #(.WIDTH(PORT_W)) u_data_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (data_pin_i),
    .sync_out (data_pin_sync)
  );

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  // Power-on reset and hardware standby clear; manual reset does not
  assign clear_regs = !aresetn || hw_standby;

  // Address port direction, write-only
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      addr_dir_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_ADDR_DIR)) begin
      addr_dir_reg <= bus.wr_data;
    end
  end

  // Address port output latch
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      addr_latch_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_ADDR_LATCH)) begin
      addr_latch_reg <= bus.wr_data;
    end
  end

  // Address port pull-up control
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      addr_pullup_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_ADDR_PULLUP)) begin
      addr_pullup_reg <= bus.wr_data;
    end
  end

  // Data port direction, write-only
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      data_dir_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_DATA_DIR)) begin
      data_dir_reg <= bus.wr_data;
    end
  end

  // Data port output latch
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      data_latch_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_DATA_LATCH)) begin
      data_latch_reg <= bus.wr_data;
    end
  end

  // Data port pull-up control
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      data_pullup_reg <= adp_pkg::RST_PORT_REG;
    end else if (wr_to(adp_pkg::IDX_DATA_PULLUP)) begin
      data_pullup_reg <= bus.wr_data;
    end
  end

  // Pin-state registers take no writes; the index still answers OKAY
  assign addr_pin_state = pin_view(addr_dir_reg, addr_latch_reg, addr_pin_sync);
  assign data_pin_state = pin_view(data_dir_reg, data_latch_reg, data_pin_sync);
  assign bus.wr_hit     = is_mapped(bus.wr_idx);

  // --------------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------------
  always_comb begin
    bus.rd_hit  = is_mapped(bus.rd_idx);
    bus.rd_data = 8'h00;
    unique case (bus.rd_idx)
      adp_pkg::IDX_ADDR_DIR:    bus.rd_data = adp_pkg::RD_WRITE_ONLY;
      adp_pkg::IDX_ADDR_LATCH:  bus.rd_data = addr_latch_reg;
      adp_pkg::IDX_ADDR_PINS:   bus.rd_data = addr_pin_state;
      adp_pkg::IDX_ADDR_PULLUP: bus.rd_data = addr_pullup_reg;
      adp_pkg::IDX_DATA_DIR:    bus.rd_data = adp_pkg::RD_WRITE_ONLY;
      adp_pkg::IDX_DATA_LATCH:  bus.rd_data = data_latch_reg;
      adp_pkg::IDX_DATA_PINS:   bus.rd_data = data_pin_state;
      adp_pkg::IDX_DATA_PULLUP: bus.rd_data = data_pullup_reg;
      default:                  bus.rd_data = 8'h00;
    endcase
  end

  // --------------------------------------------------------------------------
  // Mode classification
  // --------------------------------------------------------------------------
  // Address port: bus address, mixed address/input, or plain port
  always_comb begin
    unique case (op_mode)
      adp_pkg::MODE_1, adp_pkg::MODE_4, adp_pkg::MODE_5: addr_class = adp_pkg::MC_EXT;
      adp_pkg::MODE_2, adp_pkg::MODE_6:                  addr_class = adp_pkg::MC_MIXED;
      adp_pkg::MODE_3, adp_pkg::MODE_7:                  addr_class = adp_pkg::MC_PORT;
      default:                                           addr_class = adp_pkg::MC_NONE;
    endcase
  end

  // Data port: external data bus or plain port
  always_comb begin
    unique case (op_mode)
      adp_pkg::MODE_1, adp_pkg::MODE_2, adp_pkg::MODE_4,
      adp_pkg::MODE_5, adp_pkg::MODE_6:                  data_class = adp_pkg::MC_EXT;
      adp_pkg::MODE_3, adp_pkg::MODE_7:                  data_class = adp_pkg::MC_PORT;
      default:                                           data_class = adp_pkg::MC_NONE;
    endcase
  end

  // --------------------------------------------------------------------------
  // Per-pin drive selection
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < PORT_W; i++) begin : g_pin
    // Address port pin: source, enable and pull-up
    always_comb begin
      addr_o_next[i]  = 1'b0;
      addr_oe_next[i] = 1'b0;
      addr_pu_next[i] = 1'b0;
      unique case (addr_class)
        adp_pkg::MC_EXT: begin
          addr_o_next[i]  = bc_addr[i];
          addr_oe_next[i] = 1'b1;
        end
        adp_pkg::MC_MIXED: begin
          addr_o_next[i]  = bc_addr[i];
          addr_oe_next[i] = addr_dir_reg[i];
          addr_pu_next[i] = !addr_dir_reg[i] && addr_pullup_reg[i];
        end
        adp_pkg::MC_PORT: begin
          addr_o_next[i]  = addr_latch_reg[i];
          addr_oe_next[i] = addr_dir_reg[i];
          addr_pu_next[i] = !addr_dir_reg[i] && addr_pullup_reg[i];
        end
        adp_pkg::MC_NONE: begin
          addr_oe_next[i] = 1'b0;
        end
      endcase
    end

    // Data port pin: bus controller owns the pin in modes 1,2,4,5,6
    always_comb begin
      data_o_next[i]  = 1'b0;
      data_oe_next[i] = 1'b0;
      data_pu_next[i] = 1'b0;
      unique case (data_class)
        adp_pkg::MC_EXT: begin
          data_o_next[i]  = bc_data_out[i];
          data_oe_next[i] = bc_data_oe;
        end
        adp_pkg::MC_PORT: begin
          data_o_next[i]  = data_latch_reg[i];
          data_oe_next[i] = data_dir_reg[i];
          data_pu_next[i] = !data_dir_reg[i] && data_pullup_reg[i];
        end
        adp_pkg::MC_MIXED, adp_pkg::MC_NONE: begin
          data_oe_next[i] = 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Registered pin outputs
  // --------------------------------------------------------------------------
  // Address port pins; hardware standby releases every pin
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      addr_pin_o      <= '0;
      addr_pin_oe     <= '0;
      addr_pin_pullup <= '0;
    end else begin
      addr_pin_o      <= addr_o_next;
      addr_pin_oe     <= addr_oe_next;
      addr_pin_pullup <= addr_pu_next;
    end
  end

  // Data port pins
  always_ff @(posedge aclk) begin
    if (clear_regs) begin
      data_pin_o      <= '0;
      data_pin_oe     <= '0;
      data_pin_pullup <= '0;
    end else begin
      data_pin_o      <= data_o_next;
      data_pin_oe     <= data_oe_next;
      data_pin_pullup <= data_pu_next;
    end
  end

  // Read data handed back to the bus controller
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bc_data_in <= '0;
    end else begin
      bc_data_in <= data_pin_sync;
    end
  end

endmodule
`default_nettype wire

// File: rtl/adp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Two-flop synchroniser for pin levels
// ----------------------------------------------------------------------------
module adp_sync #(
  parameter int unsigned WIDTH = 8
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

// File: tb/adp_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module adp_pin_model (
  // Port side and far-side driver
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  input  wire logic [7:0] ext,
  output var  logic [7:0] pin_i
);
  // Port drive wins, then the pull-up, then the far side
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & (pin_pullup | ext));
endmodule
`default_nettype wire

// File: tb/adp_port_pair_properties.sv
`timescale 1ns/1ps
`default_nettype none
module adp_port_pair_properties (
  // Clock, reset, state, bus controller and data pin output
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       hw_standby,
  input wire logic [2:0] op_mode,
  input wire logic [7:0] bc_addr,
  input wire logic       bc_data_oe,
  input wire logic [7:0] bc_data_out,
  input wire logic [7:0] data_pin_o,
  // Pins
  input wire logic [7:0] addr_pin_o,
  input wire logic [7:0] addr_pin_oe,
  input wire logic [7:0] addr_pin_pullup,
  input wire logic [7:0] data_pin_oe,
  input wire logic [7:0] data_pin_pullup
);
  logic ext_a;
  logic ext_d;
  // Modes in which each port belongs to the external bus
  assign ext_a = !hw_standby && op_mode inside {3'h1, 3'h4, 3'h5};
  assign ext_d = !hw_standby && op_mode inside {3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  // Pins are registered, so each cause shows one edge later
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_addr_bus_drive: assert property (ext_a |=> addr_pin_oe == 8'hFF &&
    addr_pin_o == $past(bc_addr)) else $error("Address port not on bus");
  a_addr_mixed_drive: assert property (!hw_standby && op_mode inside {3'h2, 3'h6}
    |=> (addr_pin_o & addr_pin_oe) == ($past(bc_addr) & addr_pin_oe)) else $error("Bad address");
  a_data_bus_drive: assert property (ext_d |=> data_pin_oe == {8{$past(bc_data_oe)}})
    else $error("Data port not on bus");
  a_data_bus_value: assert property (ext_d |=> data_pin_o == $past(bc_data_out))
    else $error("Data port not carrying bus data");
  a_addr_pull_off: assert property (ext_a |=> addr_pin_pullup == 8'h00)
    else $error("Address pull-up on");
  a_data_pull_off: assert property (ext_d |=> data_pin_pullup == 8'h00)
    else $error("Data pull-up on");
  a_pull_not_drive: assert property (((addr_pin_pullup & addr_pin_oe) |
    (data_pin_pullup & data_pin_oe)) == 8'h00) else $error("Pull-up on a driven pin");
  a_standby_drive_off: assert property (hw_standby [*2] |-> (addr_pin_oe | data_pin_oe) == 8'h00)
    else $error("Pins driven in standby");
  a_standby_pull_off: assert property (hw_standby |=> (addr_pin_pullup | data_pin_pullup) == 8'h00)
    else $error("Pull-up on in standby");
endmodule
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        aclk, aresetn, hw_standby, manual_reset, bc_data_oe, awvalid, awready, wvalid;
  logic        wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  logic [2:0]  op_mode;
  logic [3:0]  wstrb;
  logic [7:0]  bc_addr, bc_data_out, bc_data_in, addr_pin_i, addr_pin_o, addr_pin_oe, ext;
  logic [7:0]  addr_pin_pullup, data_pin_i, data_pin_o, data_pin_oe, data_pin_pullup;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  int          bad_count, checked;
  // Design and the far side of both ports
  adp_port_pair #(.ADDR_W(18), .PORT_W(8)) i_adp_port_pair (.*);
  adp_pin_model i_pin_addr (.pin_o(addr_pin_o), .pin_oe(addr_pin_oe),
    .pin_pullup(addr_pin_pullup), .ext(ext), .pin_i(addr_pin_i));
  adp_pin_model i_pin_data (.pin_o(data_pin_o), .pin_oe(data_pin_oe),
    .pin_pullup(data_pin_pullup), .ext(ext), .pin_i(data_pin_i));
  // Bench clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input logic [39:0] s, input logic [39:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Counts and verdict, then stop
  task automatic give_verdict();
    $display("Mismatches %0d, comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // One AXI4-Lite write (w high) or read, with its response checked
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] d,
                      input logic [1:0] r);
    int n;
    {awaddr, araddr, wdata} <= {i, 2'h0, i, 2'h0, 24'h0, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
    n = 0;
    do begin
      @(posedge aclk);
      {awvalid, wvalid, arvalid} <= {awvalid & !awready, wvalid & !wready, arvalid & !arready};
      n++;
    end while (!(w ? bvalid : rvalid) && n < 20);
    {bready, rready} <= 2'h0;
    chk(w ? {38'h0, bresp} : {rdata, 6'h0, rresp}, {(w ? 32'h0 : {24'h0, d}), 6'h0, r});
    chk({39'h0, n < 20}, 40'h1);
    if (n == 20) give_verdict();
    @(posedge aclk); // Next request starts one edge after this release
  endtask
  // Register write and read with an OKAY answer
  task automatic put(input logic [15:0] i, input logic [7:0] d);
    xfer(1'b1, i, d, adp_pkg::RESP_OKAY);
  endtask
  task automatic get(input logic [15:0] i, input logic [7:0] d);
    xfer(1'b0, i, d, adp_pkg::RESP_OKAY);
  endtask
  // Main sequence
  initial begin
    {aresetn, hw_standby, manual_reset, bc_data_oe, awvalid, wvalid, bready, arvalid, rready} <= '0;
    {awaddr, araddr, wdata, op_mode, wstrb, bc_addr, bc_data_out, ext} <= {68'h0, 3'h3, 4'hF, 24'hC35A5A};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    get(adp_pkg::IDX_DATA_DIR, 8'h00);
    put(adp_pkg::IDX_ADDR_DIR, 8'hF0);
    put(adp_pkg::IDX_ADDR_LATCH, 8'hA5);
    put(adp_pkg::IDX_ADDR_PULLUP, 8'h0C);
    put(adp_pkg::IDX_DATA_DIR, 8'h0F);
    put(adp_pkg::IDX_DATA_LATCH, 8'h3C);
    put(adp_pkg::IDX_DATA_PULLUP, 8'h30);
    put(adp_pkg::IDX_ADDR_PINS, 8'h00);
    repeat (4) @(posedge aclk);
    chk({16'h0, addr_pin_oe, addr_pin_o & 8'hF0, addr_pin_pullup}, 40'hF0A00C);
    chk({16'h0, data_pin_oe, data_pin_o & 8'h0F, data_pin_pullup}, 40'h0F0C30);
    get(adp_pkg::IDX_ADDR_PINS, 8'hAE);
    get(adp_pkg::IDX_DATA_PINS, 8'h7C);
    xfer(1'b0, 16'h0001, 8'h00, adp_pkg::RESP_SLVERR);
    op_mode <= 3'h2;
    repeat (3) @(posedge aclk);
    {op_mode, manual_reset} <= {3'h3, 1'b1};
    put(adp_pkg::IDX_ADDR_LATCH, 8'h11);
    manual_reset <= 1'b0;
    get(adp_pkg::IDX_ADDR_LATCH, 8'hA5);
    hw_standby <= 1'b1;
    repeat (3) @(posedge aclk);
    hw_standby <= 1'b0;
    get(adp_pkg::IDX_ADDR_PULLUP, 8'h00);
    // Every mode in turn, direction bits cleared by standby
    for (int m = 1; m < 8; m++) begin
      {op_mode, bc_data_oe, bc_addr, ext} <= {m[2:0], m[0], 8'h96 ^ m[7:0], 8'h21 ^ m[7:0]};
      repeat (5) @(posedge aclk); // Pin register, two sync flops, return register
      chk({32'h0, addr_pin_oe}, m inside {1, 4, 5} ? 40'hFF : 40'h0);
      chk({32'h0, data_pin_oe}, m[1:0] == 2'h3 ? 40'h0 : {40{m[0]}} & 40'hFF);
      chk({32'h0, bc_data_in}, m inside {1, 5} ? 40'h5A : 40'h21 ^ m);
    end
    give_verdict();
  end
endmodule
bind adp_port_pair adp_port_pair_properties i_adp_port_pair_properties (.*);
`default_nettype wire
